// ===== hw/gls_cfg.svh
/*
 * Constants of the guard-lock switch logic: clock rate, timing figures,
 * synchroniser width and input bit positions inside the synchroniser vector.
 * Assumes it is included by bare name from the design files.
 */
`ifndef GLS_CFG_SVH
`define GLS_CFG_SVH

// System clock in hertz
`define GLS_CLK_HZ 40000000
// Settling time before the holding force is judged, in milliseconds
`define GLS_FORCE_SETTLE_MS 50
// Half period of the flashing lock indicator, in milliseconds
`define GLS_FLASH_HALF_MS 250
// Width of the timing counters
`define GLS_CNT_W 24

// Positions of the synchronised inputs
`define GLS_IN_CH_A 0
`define GLS_IN_CH_B 1
`define GLS_IN_REQ 2
`define GLS_IN_CHAIN 3
`define GLS_IN_ACT 4
`define GLS_IN_BUS_ATT 5
`define GLS_IN_BUS_ACT 6
`define GLS_IN_BUS_CMD 7
`define GLS_IN_FORCE_OK 8
`define GLS_IN_WIN_OPEN 9
`define GLS_IN_WIN_SHORT 10
`define GLS_IN_MAG_OP 11
`define GLS_IN_MAG_MON 12
`define GLS_IN_BUS_TX 13
`define GLS_IN_W 14

`endif

// ===== hw/gls_pkg.sv
/*
 * Types of the guard-lock switch logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gls_pkg;

   // Guard locking sequence
   typedef enum logic [2:0] {
      LK_IDLE,
      LK_ENGAGE,
      LK_HELD,
      LK_WARN,
      LK_FAULT
   } gls_lock_state_t;

endpackage

// ===== hw/gls_sync.sv
/*
 * Two-stage synchroniser for a vector of unrelated level inputs.
 * Assumes each bit is a slow level; no bit-to-bit coherence is promised.
 */
module gls_sync
#(
   parameter int WIDTH = 2
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule // gls_sync

// ===== hw/gls_guard_lock.sv
/*
 * Decision logic of a guard-locking safety gate switch: safety output pair,
 * channel plausibility, guard lock sequencing, magnet fault handling, status
 * chain output and indicators.
 * Assumes actuator detection, force measurement, magnet diagnostics and the
 * diagnostic bus framing are done outside and arrive as plain levels.
 */
// Functional notes
// - Outputs high only with actuator, both channels, lock request, holding force.
// - Active bus mode also needs the bus activation command.
// - Any missing condition other than holding force drops both outputs.
// - Each output gated by its own channel input.
// - One channel falling while other stays high flags unequal channels.
// - Fallen channel rising again gives plausibility error and partial lock.
// - Both channels low together clears partial lock and allows rise.
// - Gate forced open while locked drops outputs and enters fault.
// - Fault lights device indicator red, flashes lock indicator red.
// - Without bus, status is actuator and error-free and chain input.
// - With bus module, status carries bus data, chain input receives.
// - Chained status outputs feed next chain input; last shows all present.
// - Lock request with actuator present requests guard locking.
// - Lock request low releases locking and drops outputs.
// - Magnet on with actuator and request; active bus also needs command.
// - Holding force measured after locking confirms the outputs.
// - Relocking only after lock request goes low then high again.
// - Force not reached shows warning, outputs low, no fault.
// - Magnet winding or monitoring faults while energised enter fault.
// - Restart begins without bus operation, locking by request only; here bus operation follows the bus inputs three cycles after reset.
`include "gls_cfg.svh"

module gls_guard_lock
   import gls_pkg::*;
#(
   parameter int CLK_HZ = `GLS_CLK_HZ,
   parameter int SETTLE_CYC = (CLK_HZ / 1000) * `GLS_FORCE_SETTLE_MS,
   parameter int FLASH_CYC = (CLK_HZ / 1000) * `GLS_FLASH_HALF_MS
)
(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // Channel and lock request inputs from the controller
   input wire logic CHANNEL_A_I,
   input wire logic CHANNEL_B_I,
   input wire logic LOCK_REQUEST_I,
   // Chain input from the upstream switch or the bus
   input wire logic CHAIN_I,
   // Sensing of actuator, force and magnet
   input wire logic ACTUATOR_PRESENT_I,
   input wire logic FORCE_OK_I,
   input wire logic WINDING_OPEN_I,
   input wire logic WINDING_SHORT_I,
   input wire logic MAGNET_OP_FAULT_I,
   input wire logic MAGNET_MON_FAULT_I,
   // Diagnostic bus side
   input wire logic BUS_ATTACHED_I,
   input wire logic BUS_ACTIVE_MODE_I,
   input wire logic BUS_LOCK_CMD_I,
   input wire logic BUS_TX_DATA_I,
   output logic BUS_RX_DATA_O,
   // Safety output pair and status chain output
   output logic SAFETY_A_O,
   output logic SAFETY_B_O,
   output logic STATUS_CHAIN_O,
   // Magnet drive
   output logic MAGNET_ON_O,
   // Status and indicators
   output logic UNEQUAL_O,
   output logic PARTIAL_LOCK_O,
   output logic FORCE_WARN_O,
   output logic FAULT_O,
   output logic LED_DEVICE_RED_O,
   output logic LED_LOCK_RED_O
);

   localparam logic [`GLS_CNT_W-1:0] SETTLE_LAST = `GLS_CNT_W'(SETTLE_CYC - 1);
   localparam logic [`GLS_CNT_W-1:0] FLASH_LAST = `GLS_CNT_W'(FLASH_CYC - 1);

   logic [`GLS_IN_W-1:0] raw_in;
   logic [`GLS_IN_W-1:0] syn;
   logic ch_a, ch_b, req, chain, act, bus_att, bus_act_in, bus_cmd;
   logic force_ok, mag_err, bus_tx;
   logic ch_a_ff, ch_b_ff;
   logic unequal_ff, nxt_unequal;
   logic partial_lock_ff, nxt_partial_lock;
   logic bus_active_ff;
   logic req_seen_low_ff, nxt_req_seen_low;
   gls_lock_state_t lock_st_ff, nxt_lock_st;
   logic [`GLS_CNT_W-1:0] settle_cnt_ff, nxt_settle_cnt;
   logic [`GLS_CNT_W-1:0] flash_cnt_ff, nxt_flash_cnt;
   logic flash_ff;
   logic safety_a_ff, safety_b_ff, status_ff, magnet_ff, rx_ff;
   logic bus_ok, lock_grant, magnet_want, forced_open, enable_all, error_free;
   logic a_fall, b_fall, a_rise, b_rise, both_low;

   // Pack inputs so one synchroniser instance serves them all
   assign raw_in[`GLS_IN_CH_A] = CHANNEL_A_I;
   assign raw_in[`GLS_IN_CH_B] = CHANNEL_B_I;
   assign raw_in[`GLS_IN_REQ] = LOCK_REQUEST_I;
   assign raw_in[`GLS_IN_CHAIN] = CHAIN_I;
   assign raw_in[`GLS_IN_ACT] = ACTUATOR_PRESENT_I;
   assign raw_in[`GLS_IN_BUS_ATT] = BUS_ATTACHED_I;
   assign raw_in[`GLS_IN_BUS_ACT] = BUS_ACTIVE_MODE_I;
   assign raw_in[`GLS_IN_BUS_CMD] = BUS_LOCK_CMD_I;
   assign raw_in[`GLS_IN_FORCE_OK] = FORCE_OK_I;
   assign raw_in[`GLS_IN_WIN_OPEN] = WINDING_OPEN_I;
   assign raw_in[`GLS_IN_WIN_SHORT] = WINDING_SHORT_I;
   assign raw_in[`GLS_IN_MAG_OP] = MAGNET_OP_FAULT_I;
   assign raw_in[`GLS_IN_MAG_MON] = MAGNET_MON_FAULT_I;
   assign raw_in[`GLS_IN_BUS_TX] = BUS_TX_DATA_I;

   // All external levels pass two flops before use
   gls_sync #(
      .WIDTH(`GLS_IN_W)
   ) u_sync (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .async_i(raw_in),
      .sync_o(syn)
   );

   // Named views of the synchronised inputs
   assign ch_a = syn[`GLS_IN_CH_A];
   assign ch_b = syn[`GLS_IN_CH_B];
   assign req = syn[`GLS_IN_REQ];
   assign chain = syn[`GLS_IN_CHAIN];
   assign act = syn[`GLS_IN_ACT];
   assign bus_att = syn[`GLS_IN_BUS_ATT];
   assign bus_act_in = syn[`GLS_IN_BUS_ACT];
   assign bus_cmd = syn[`GLS_IN_BUS_CMD];
   assign force_ok = syn[`GLS_IN_FORCE_OK];
   assign bus_tx = syn[`GLS_IN_BUS_TX];
   assign mag_err = syn[`GLS_IN_WIN_OPEN] | syn[`GLS_IN_WIN_SHORT]
                    | syn[`GLS_IN_MAG_OP] | syn[`GLS_IN_MAG_MON];

   // Channel edges against last cycle's levels
   assign a_fall = ch_a_ff & ~ch_a;
   assign b_fall = ch_b_ff & ~ch_b;
   assign a_rise = ~ch_a_ff & ch_a;
   assign b_rise = ~ch_b_ff & ch_b;
   assign both_low = ~ch_a & ~ch_b;

   // Plausibility: unequal flag and partial operation lock
   assign nxt_unequal = both_low ? 1'b0
                      : (a_fall & ch_b & ch_b_ff) | (b_fall & ch_a & ch_a_ff) ? 1'b1
                      : unequal_ff;
   assign nxt_partial_lock = both_low ? 1'b0
                           : unequal_ff & ((a_rise & ch_b & ch_b_ff) | (b_rise & ch_a & ch_a_ff)) ? 1'b1
                           : partial_lock_ff;

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         ch_a_ff <= 1'b0;
         ch_b_ff <= 1'b0;
         unequal_ff <= 1'b0;
         partial_lock_ff <= 1'b0;
      end
      else
      begin
         ch_a_ff <= ch_a;
         ch_b_ff <= ch_b;
         unequal_ff <= nxt_unequal;
         partial_lock_ff <= nxt_partial_lock;
      end
   end

   // Bus operation is off in reset and follows the synchronised bus inputs from then on; the bus is not trusted for safety
   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
         bus_active_ff <= 1'b0;
      else
         bus_active_ff <= bus_att & bus_act_in;
   end

   // Locking permission: request, actuator, and command in active bus mode
   assign bus_ok = ~bus_active_ff | bus_cmd;
   assign lock_grant = req & act & bus_ok;
   assign forced_open = ~act & ((lock_st_ff == LK_HELD) | (lock_st_ff == LK_ENGAGE));
   assign nxt_req_seen_low = ~req ? 1'b1
                           : (nxt_lock_st == LK_ENGAGE) ? 1'b0
                           : req_seen_low_ff;

   // Guard locking sequence
   always_comb
   begin
      nxt_lock_st = lock_st_ff;
      nxt_settle_cnt = settle_cnt_ff;
      case (lock_st_ff)
         LK_IDLE:
         begin
            if (lock_grant && req_seen_low_ff)
            begin
               nxt_lock_st = LK_ENGAGE;
               nxt_settle_cnt = '0;
            end
         end
         LK_ENGAGE:
         begin
            nxt_settle_cnt = settle_cnt_ff + `GLS_CNT_W'(1);
            if (settle_cnt_ff == SETTLE_LAST)
               nxt_lock_st = force_ok ? LK_HELD : LK_WARN;
         end
         LK_HELD:
            nxt_lock_st = LK_HELD;
         LK_WARN:
            nxt_lock_st = LK_WARN;
         LK_FAULT:
            nxt_lock_st = LK_FAULT;
         default:
            nxt_lock_st = LK_FAULT;
      endcase
      // Faults override the sequence, release follows otherwise
      if (lock_st_ff != LK_FAULT)
      begin
         if (forced_open || (magnet_ff && mag_err))
            nxt_lock_st = LK_FAULT;
         else if (lock_st_ff != LK_IDLE && !lock_grant)
            nxt_lock_st = LK_IDLE;
      end
   end

   assign magnet_want = (nxt_lock_st == LK_ENGAGE) | (nxt_lock_st == LK_HELD) | (nxt_lock_st == LK_WARN);

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         lock_st_ff <= LK_IDLE;
         settle_cnt_ff <= '0;
         req_seen_low_ff <= 1'b1;
         magnet_ff <= 1'b0;
      end
      else
      begin
         lock_st_ff <= nxt_lock_st;
         settle_cnt_ff <= nxt_settle_cnt;
         req_seen_low_ff <= nxt_req_seen_low;
         magnet_ff <= magnet_want;
      end
   end

   // Output enable: every condition at once, re-judged every cycle
   assign error_free = ~partial_lock_ff & (lock_st_ff != LK_FAULT);
   assign enable_all = act & ch_a & ch_b & req & bus_ok & error_free
                       & (lock_st_ff == LK_HELD) & (nxt_lock_st == LK_HELD);

   // Status chain: plain signal without bus module, bus transmit data with one
   assign BUS_RX_DATA_O = rx_ff;

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         safety_a_ff <= 1'b0;
         safety_b_ff <= 1'b0;
         status_ff <= 1'b0;
         rx_ff <= 1'b0;
      end
      else
      begin
         safety_a_ff <= enable_all & ch_a;
         safety_b_ff <= enable_all & ch_b;
         status_ff <= bus_att ? bus_tx : (act & error_free & chain);
         rx_ff <= bus_att & chain;
      end
   end

   // Flash timer for the lock indicator; runs only while faulted
   assign nxt_flash_cnt = (lock_st_ff != LK_FAULT || flash_cnt_ff == FLASH_LAST)
                          ? '0 : flash_cnt_ff + `GLS_CNT_W'(1);

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         flash_cnt_ff <= '0;
         flash_ff <= 1'b0;
      end
      else
      begin
         flash_cnt_ff <= nxt_flash_cnt;
         if (lock_st_ff != LK_FAULT)
            flash_ff <= 1'b0;
         else if (flash_cnt_ff == FLASH_LAST)
            flash_ff <= ~flash_ff;
      end
   end

   // Output drive, all from flip-flops
   assign SAFETY_A_O = safety_a_ff;
   assign SAFETY_B_O = safety_b_ff;
   assign STATUS_CHAIN_O = status_ff;
   assign MAGNET_ON_O = magnet_ff;
   assign UNEQUAL_O = unequal_ff;
   assign PARTIAL_LOCK_O = partial_lock_ff;
   assign FORCE_WARN_O = (lock_st_ff == LK_WARN);
   assign FAULT_O = (lock_st_ff == LK_FAULT);
   assign LED_DEVICE_RED_O = (lock_st_ff == LK_FAULT);
   assign LED_LOCK_RED_O = flash_ff;

   // Checks on the safety decisions

   property p_all_conditions;
      @(posedge CLOCK_I) disable iff (RST_I)
      SAFETY_A_O |-> $past(act && ch_a && ch_b && req && lock_st_ff == LK_HELD);
   endproperty
   a_all_conditions: assert property (p_all_conditions) else $error("output high without all conditions");

   property p_bus_cmd;
      @(posedge CLOCK_I) disable iff (RST_I)
      (bus_active_ff && !bus_cmd) |=> !SAFETY_A_O && !SAFETY_B_O;
   endproperty
   a_bus_cmd: assert property (p_bus_cmd) else $error("output high without bus command");

   property p_drop_any;
      @(posedge CLOCK_I) disable iff (RST_I)
      (!act || !req) |=> !SAFETY_A_O && !SAFETY_B_O;
   endproperty
   a_drop_any: assert property (p_drop_any) else $error("outputs not dropped");

   property p_own_channel;
      @(posedge CLOCK_I) disable iff (RST_I)
      SAFETY_B_O |-> $past(ch_b);
   endproperty
   a_own_channel: assert property (p_own_channel) else $error("output b without channel b");

   property p_unequal;
      @(posedge CLOCK_I) disable iff (RST_I)
      ($fell(ch_a) && ch_b && $past(ch_b)) |=> UNEQUAL_O;
   endproperty
   a_unequal: assert property (p_unequal) else $error("unequal channels not flagged");

   property p_partial_off;
      @(posedge CLOCK_I) disable iff (RST_I)
      PARTIAL_LOCK_O |=> !SAFETY_A_O && !SAFETY_B_O;
   endproperty
   a_partial_off: assert property (p_partial_off) else $error("output high in partial lock");

   property p_partial_clear;
      @(posedge CLOCK_I) disable iff (RST_I)
      both_low |=> !PARTIAL_LOCK_O && !UNEQUAL_O;
   endproperty
   a_partial_clear: assert property (p_partial_clear) else $error("partial lock not cleared");

   property p_forced_open;
      @(posedge CLOCK_I) disable iff (RST_I)
      (lock_st_ff == LK_HELD && !act) |=> FAULT_O && LED_DEVICE_RED_O ##1 !SAFETY_A_O;
   endproperty
   a_forced_open: assert property (p_forced_open) else $error("forced opening not faulted");

   property p_release;
      @(posedge CLOCK_I) disable iff (RST_I)
      !req |=> !MAGNET_ON_O;
   endproperty
   a_release: assert property (p_release) else $error("magnet on with request low");

   property p_warn_no_fault;
      @(posedge CLOCK_I) disable iff (RST_I)
      FORCE_WARN_O |-> !FAULT_O ##1 !SAFETY_A_O;
   endproperty
   a_warn_no_fault: assert property (p_warn_no_fault) else $error("warning with output high");

   property p_magnet_fault;
      @(posedge CLOCK_I) disable iff (RST_I)
      (MAGNET_ON_O && mag_err) |=> FAULT_O;
   endproperty
   a_magnet_fault: assert property (p_magnet_fault) else $error("magnet fault missed");

   property p_fault_latch;
      @(posedge CLOCK_I) disable iff (RST_I)
      FAULT_O |=> FAULT_O && !MAGNET_ON_O;
   endproperty
   a_fault_latch: assert property (p_fault_latch) else $error("fault not held");

   property p_status_plain;
      @(posedge CLOCK_I) disable iff (RST_I)
      (!bus_att && (!act || !chain)) |=> !STATUS_CHAIN_O;
   endproperty
   a_status_plain: assert property (p_status_plain) else $error("status high wrongly");

endmodule // gls_guard_lock

// ===== sim/gls_ctrl_model.sv
/*
 * Behavioural model of the safety controller facing the switch: drives the
 * two channel inputs and the lock request, and watches the safety outputs.
 * Assumes one clock shared with the switch and wishes from the bench.
 */
module gls_ctrl_model
#(
   parameter int MIN_LOW = 4
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishes from the bench
   input wire logic want_a_i,
   input wire logic want_b_i,
   input wire logic want_req_i,
   // Safety outputs watched
   input wire logic safety_a_i,
   input wire logic safety_b_i,
   // Drive towards the switch
   output logic ch_a_o,
   output logic ch_b_o,
   output logic req_o,
   output int viol_o
);
   timeunit 1ns;
   timeprecision 100ps;

   int low_cnt;
   logic a_w, b_w, r_w;

   // Quiet start, first raise allowed at once
   initial
   begin
      ch_a_o = 1'b0;
      ch_b_o = 1'b0;
      req_o = 1'b0;
      viol_o = 0;
      low_cnt = MIN_LOW;
   end

   // Check first, then drive just after the edge
   always @(posedge clk_i)
   begin
      // Outputs may lag a falling request by the pipeline only
      if (!rst_i && (safety_a_i === 1'b1 || safety_b_i === 1'b1) && low_cnt > 4)
         viol_o++;
      // Wishes taken at the edge, before the bench moves them again
      a_w = want_a_i;
      b_w = want_b_i;
      r_w = want_req_i;
      #1;
      ch_a_o = a_w;
      ch_b_o = b_w;
      if (!r_w)
         req_o = 1'b0;
      else if (low_cnt >= MIN_LOW)
         req_o = 1'b1;
      low_cnt = req_o ? 0 : low_cnt + 1;
   end
endmodule // gls_ctrl_model

// ===== sim/gls_guard_lock_tb.sv
/*
 * Self-checking bench of the guard-lock switch logic with shortened timings.
 * Assumes the controller model drives channels and request; bench drives rest.
 */
module gls_guard_lock_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SA = 0, SB = 1, ST = 2, MAG = 3, UNEQ = 4, PART = 5;
   localparam int WARN = 6, FLT = 7, LDEV = 8, LLOCK = 9, RX = 10;

   logic clk, rst, act, force_ok, w_open, w_short, m_op, m_mon;
   logic bus_att, bus_act, bus_cmd, bus_tx, chain, want_a, want_b, want_req;
   logic ch_a, ch_b, req, sa, sb, st, mag, uneq, part, warn, flt, led_dev, led_lock, rx;
   int viol, err_total, n_checks, cycles;
   wire logic [10:0] obs = {rx, led_lock, led_dev, flt, warn, part, uneq, mag, st, sb, sa};

   gls_ctrl_model #(.MIN_LOW(4)) ctrl (.clk_i(clk), .rst_i(rst), .want_a_i(want_a), .want_b_i(want_b),
      .want_req_i(want_req), .safety_a_i(sa), .safety_b_i(sb), .ch_a_o(ch_a), .ch_b_o(ch_b),
      .req_o(req), .viol_o(viol));

   gls_guard_lock #(.SETTLE_CYC(8), .FLASH_CYC(4)) dut (.CLOCK_I(clk), .RST_I(rst),
      .CHANNEL_A_I(ch_a), .CHANNEL_B_I(ch_b), .LOCK_REQUEST_I(req), .CHAIN_I(chain),
      .ACTUATOR_PRESENT_I(act), .FORCE_OK_I(force_ok), .WINDING_OPEN_I(w_open),
      .WINDING_SHORT_I(w_short), .MAGNET_OP_FAULT_I(m_op), .MAGNET_MON_FAULT_I(m_mon),
      .BUS_ATTACHED_I(bus_att), .BUS_ACTIVE_MODE_I(bus_act), .BUS_LOCK_CMD_I(bus_cmd),
      .BUS_TX_DATA_I(bus_tx), .BUS_RX_DATA_O(rx), .SAFETY_A_O(sa), .SAFETY_B_O(sb),
      .STATUS_CHAIN_O(st), .MAGNET_ON_O(mag), .UNEQUAL_O(uneq), .PARTIAL_LOCK_O(part),
      .FORCE_WARN_O(warn), .FAULT_O(flt), .LED_DEVICE_RED_O(led_dev), .LED_LOCK_RED_O(led_lock));

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Hang guard, well above the few hundred cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         stop_test();
      end
   end

   // Step n edges, then land a small delay after the last one
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input int k, input logic exp);
      n_checks++;
      if (obs[k] !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t sig %0d got %h exp %h", $time, k, obs[k], exp);
      end
   endtask

   // Bounded wait on an output, then compare
   task automatic await(input int k, input logic v);
      int i;
      i = 0;
      while (obs[k] !== v && i < 40)
      begin
         cyc(1);
         i++;
      end
      chk(k, v);
   endtask

   // Six cycles of reset with every input quiet; chain tied high as installed
   task automatic do_reset();
      rst = 1'b1;
      {act, force_ok, w_open, w_short, m_op, m_mon} = 6'h00;
      {bus_att, bus_act, bus_cmd, bus_tx, want_a, want_b, want_req} = 7'h00;
      chain = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(1);
   endtask

   // Request locking with all conditions present
   task automatic lock(input logic fok);
      act = 1'b1;
      force_ok = fok;
      {want_a, want_b, want_req} = 3'h7;
      await(MAG, 1'b1);
   endtask

   // Drop the request long enough for the model, then raise it again
   task automatic relock();
      want_req = 1'b0;
      cyc(8);
      want_req = 1'b1;
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      err_total = 0;
      n_checks = 0;
      cycles = 0;
      do_reset();
      for (int k = 0; k < 11; k++)
         chk(k, 1'b0);
      // Plain locking without the bus
      lock(1'b1);
      await(SA, 1'b1);
      chk(SB, 1'b1);
      chk(ST, 1'b1);
      chain = 1'b0;
      cyc(4);
      chk(ST, 1'b0);
      chain = 1'b1;
      want_req = 1'b0;
      await(SA, 1'b0);
      chk(SB, 1'b0);
      chk(MAG, 1'b0);
      cyc(8);
      want_req = 1'b1;
      await(SA, 1'b1);
      // Holding force missed: warning only, no relock while request stays high
      want_req = 1'b0;
      cyc(8);
      force_ok = 1'b0;
      want_req = 1'b1;
      await(WARN, 1'b1);
      chk(SA, 1'b0);
      chk(FLT, 1'b0);
      force_ok = 1'b1;
      cyc(20);
      chk(SA, 1'b0);
      relock();
      await(SA, 1'b1);
      // Channel plausibility
      want_a = 1'b0;
      await(UNEQ, 1'b1);
      chk(SA, 1'b0);
      chk(SB, 1'b0);
      want_a = 1'b1;
      await(PART, 1'b1);
      cyc(4);
      chk(SB, 1'b0);
      chk(ST, 1'b0);
      {want_a, want_b} = 2'h0;
      await(PART, 1'b0);
      chk(UNEQ, 1'b0);
      {want_a, want_b} = 2'h3;
      relock();
      await(SA, 1'b1);
      // Gate forced open while locked
      act = 1'b0;
      await(FLT, 1'b1);
      chk(LDEV, 1'b1);
      chk(SA, 1'b0);
      await(LLOCK, 1'b1);
      await(LLOCK, 1'b0);
      act = 1'b1;
      relock();
      cyc(20);
      chk(FLT, 1'b1);
      chk(MAG, 1'b0);
      // Each magnet fault while energised
      for (int f = 0; f < 4; f++)
      begin
         do_reset();
         lock(1'b1);
         await(SA, 1'b1);
         {m_mon, m_op, w_short, w_open} = 4'h1 << f;
         await(FLT, 1'b1);
         chk(SA, 1'b0);
      end
      // Diagnostic bus attached in active mode: status and receive path, then locking on command
      do_reset();
      {bus_att, bus_act, bus_tx} = 3'h7;
      chain = 1'b0;
      cyc(4);
      chk(ST, 1'b1);
      chk(RX, 1'b0);
      bus_tx = 1'b0;
      chain = 1'b1;
      cyc(4);
      chk(ST, 1'b0);
      chk(RX, 1'b1);
      act = 1'b1;
      force_ok = 1'b1;
      {want_a, want_b, want_req} = 3'h7;
      cyc(20);
      chk(MAG, 1'b0);
      chk(SA, 1'b0);
      bus_cmd = 1'b1;
      await(MAG, 1'b1);
      await(SA, 1'b1);
      // Controller view of the outputs over the whole run
      n_checks++;
      if (viol != 0)
      begin
         err_total++;
         $display("[ERR] t=%0t controller saw %h exp %h", $time, viol, 0);
      end
      stop_test();
   end
endmodule // gls_guard_lock_tb
